// File: hdl/eeprom_read_regs.vh
// constants for the serial eeprom read engine
`ifndef EEPROM_READ_REGS_VH
`define EEPROM_READ_REGS_VH

`define EE_CTRL_CODE   4'hA
`define EE_ADDR_W      13
`define EE_ADDR_TOP    13'h1FFF
`define EE_ADDR_BOTTOM 13'h0000
`define EE_PTR_RESET   13'h0000
`define EE_HI_BITS     5
`define EE_BYTE_BITS   4'h8
`define EE_IDLE_BYTE   8'hFF
`define EE_FIFO_WIDTH  8
`define EE_FIFO_DEPTH  8
`define EE_FIFO_AW     3
`define EE_PH_CTRL     2'h0
`define EE_PH_AHI      2'h1
`define EE_PH_ALO      2'h2
`define EE_PH_WDATA    2'h3

`endif

// File: hdl/byte_fifo.v
// small flop-based fifo with valid/ready on both sides and a flush
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_read_regs.vh"

module byte_fifo #(
  parameter WIDTH = `EE_FIFO_WIDTH,
  parameter DEPTH = `EE_FIFO_DEPTH,
  parameter AW    = `EE_FIFO_AW
) (
  // clock and control
  input  wire             clk_i,
  input  wire             resetn_i,
  input  wire             clk_en_i,
  input  wire             flush_i,
  // fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  localparam [31:0]   DEPTH_W = DEPTH;
  localparam [31:0]   LAST_W  = DEPTH - 1;
  localparam [AW:0]   FULL    = DEPTH_W[AW:0];
  localparam [AW-1:0] LAST    = LAST_W[AW-1:0];

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_r;
  reg [AW-1:0]    rd_r;
  reg [AW:0]      cnt_r;

  wire push = in_valid_i & in_ready_o;
  wire pop  = out_valid_o & out_ready_i;

  assign in_ready_o  = (cnt_r != FULL);
  assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
  assign out_data_o  = mem_r[rd_r];

  always @(posedge clk_i) begin
    if (!resetn_i) begin
      wr_r  <= {AW{1'b0}};
      rd_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else if (clk_en_i) begin
      if (flush_i) begin
        wr_r  <= {AW{1'b0}};
        rd_r  <= {AW{1'b0}};
        cnt_r <= {(AW+1){1'b0}};
      end else begin
        if (push) begin
          mem_r[wr_r] <= in_data_i;
          wr_r        <= (wr_r == LAST) ? {AW{1'b0}} : wr_r + 1'b1;
        end
        if (pop)
          rd_r <= (rd_r == LAST) ? {AW{1'b0}} : rd_r + 1'b1;
        if (push && !pop)
          cnt_r <= cnt_r + 1'b1;
        else if (pop && !push)
          cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// File: hdl/eeprom_read_engine.v
// two-wire serial eeprom read engine with prefetch fifo
//
// Behaviour
// - read begins with start, control byte, bit one
// - current, random and sequential reads supported
// - pointer holds last accessed address plus one
// - matching read control byte: ack, send byte
// - host nack and stop end the read
// - repeated start abandons write, keeps pointer
// - read control after restart: ack, send byte
// - after random read pointer is next address
// - host ack fetches byte at next address
// - pointer increments after every byte sent to the host
// - pointer wraps from top to bottom location
// - respond only to code and chip select match
// - address high byte first, low thirteen bits
// - no ack while programming cycle runs
// - release data line after host nack
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_read_regs.vh"

module eeprom_read_engine (
  // clock, reset, enable
  input  wire                  ref_clk_i,
  input  wire                  resetn_i,
  input  wire                  clk_en_i,
  // serial bus, open drain data line
  input  wire                  scl_i,
  input  wire                  sda_i,
  output wire                  sda_o,
  output wire                  sda_oe_o,
  // straps and array status
  input  wire [2:0]            chip_select_pins_i,
  input  wire                  prog_busy_i,
  // array read port
  output wire [`EE_ADDR_W-1:0] rd_addr_o,
  input  wire [7:0]            rd_data_i,
  input  wire                  rd_valid_i,
  output wire                  rd_ready_o,
  // observed pointer
  output wire [`EE_ADDR_W-1:0] ptr_o
);
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_RX   = 6'h02;
  localparam [5:0] ST_RACK = 6'h04;
  localparam [5:0] ST_TX   = 6'h08;
  localparam [5:0] ST_MACK = 6'h10;
  localparam [5:0] ST_WAIT = 6'h20;

  // pin synchronisers plus one history stage for edge finding
  reg       scl_s1_r;
  reg       scl_s2_r;
  reg       scl_d_r;
  reg       sda_s1_r;
  reg       sda_s2_r;
  reg       sda_d_r;
  reg [2:0] cs_s1_r;
  reg [2:0] cs_s2_r;

  reg [5:0]            state_r;
  reg [1:0]            phase_r;
  reg [3:0]            bit_r;
  reg [7:0]            sh_r;
  reg [7:0]            tx_r;
  reg                  rd_mode_r;
  reg                  host_ack_r;
  reg [`EE_HI_BITS-1:0] addr_hi_r;
  reg [`EE_ADDR_W-1:0] ptr_r;
  reg [`EE_ADDR_W-1:0] fetch_r;
  reg                  sda_oe_r;
  reg                  flush_r;

  wire       fifo_in_ready;
  wire       fifo_valid;
  wire [7:0] fifo_data;

  wire scl_rise  = scl_s2_r & ~scl_d_r;
  wire scl_fall  = ~scl_s2_r & scl_d_r;
  wire start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  wire stop_det  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
  wire quiet     = ~start_det & ~stop_det;

  wire ctrl_match = (sh_r[7:4] == `EE_CTRL_CODE) &&
                    (sh_r[3:1] == cs_s2_r);
  wire can_ack    = ~prog_busy_i;

  // a new byte goes out after the control ack of a read or a host ack
  wire load_tx = clk_en_i & quiet & scl_fall &
                 (((state_r == ST_RACK) & (phase_r == `EE_PH_CTRL) &
                   rd_mode_r) |
                  ((state_r == ST_MACK) & host_ack_r));
  // an empty fifo sends the idle level rather than stalling the bus
  wire [7:0] tx_byte = fifo_valid ? fifo_data : `EE_IDLE_BYTE;

  wire [`EE_ADDR_W-1:0] ptr_inc =
    (ptr_r == `EE_ADDR_TOP) ? `EE_ADDR_BOTTOM : ptr_r + 1'b1;
  wire [`EE_ADDR_W-1:0] fetch_inc =
    (fetch_r == `EE_ADDR_TOP) ? `EE_ADDR_BOTTOM : fetch_r + 1'b1;

  assign sda_o      = 1'b0;
  assign sda_oe_o   = sda_oe_r;
  assign ptr_o      = ptr_r;
  assign rd_addr_o  = fetch_r;
  // no fetch in the flush cycle, so stale addresses never land
  assign rd_ready_o = fifo_in_ready & ~flush_r;

  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r  <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r  <= 1'b1;
      cs_s1_r  <= 3'h0;
      cs_s2_r  <= 3'h0;
    end else if (clk_en_i) begin
      scl_s1_r <= scl_i;
      scl_s2_r <= scl_s1_r;
      scl_d_r  <= scl_s2_r;
      sda_s1_r <= sda_i;
      sda_s2_r <= sda_s1_r;
      sda_d_r  <= sda_s2_r;
      cs_s1_r  <= chip_select_pins_i;
      cs_s2_r  <= cs_s1_r;
    end
  end

  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_r    <= ST_IDLE;
      phase_r    <= `EE_PH_CTRL;
      bit_r      <= 4'h0;
      sh_r       <= 8'h00;
      tx_r       <= 8'h00;
      rd_mode_r  <= 1'b0;
      host_ack_r <= 1'b0;
      addr_hi_r  <= {`EE_HI_BITS{1'b0}};
      ptr_r      <= `EE_PTR_RESET;
      sda_oe_r   <= 1'b0;
      flush_r    <= 1'b0;
    end else if (clk_en_i) begin
      flush_r <= 1'b0;
      if (stop_det) begin
        state_r  <= ST_IDLE;
        sda_oe_r <= 1'b0;
        flush_r  <= 1'b1;
      end else if (start_det) begin
        // a restart mid-write drops it; ptr_r is left as loaded
        state_r  <= ST_RX;
        phase_r  <= `EE_PH_CTRL;
        bit_r    <= 4'h0;
        sda_oe_r <= 1'b0;
        flush_r  <= 1'b1;
      end else begin
        case (state_r)
          ST_IDLE: begin
          end
          ST_WAIT: begin
          end
          ST_RX: begin
            if (scl_rise && bit_r != `EE_BYTE_BITS) begin
              sh_r  <= {sh_r[6:0], sda_s2_r};
              bit_r <= bit_r + 1'b1;
            end else if (scl_fall && bit_r == `EE_BYTE_BITS) begin
              state_r <= ST_WAIT;
              if (can_ack) begin
                case (phase_r)
                  `EE_PH_CTRL: begin
                    if (ctrl_match) begin
                      state_r   <= ST_RACK;
                      sda_oe_r  <= 1'b1;
                      rd_mode_r <= sh_r[0];
                    end
                  end
                  `EE_PH_AHI: begin
                    addr_hi_r <= sh_r[`EE_HI_BITS-1:0];
                    state_r   <= ST_RACK;
                    sda_oe_r  <= 1'b1;
                  end
                  `EE_PH_ALO: begin
                    ptr_r    <= {addr_hi_r, sh_r};
                    flush_r  <= 1'b1;
                    state_r  <= ST_RACK;
                    sda_oe_r <= 1'b1;
                  end
                  default: begin
                  end
                endcase
              end
            end
          end
          ST_RACK: begin
            if (scl_fall) begin
              bit_r <= 4'h0;
              if (load_tx) begin
                tx_r     <= tx_byte;
                sda_oe_r <= ~tx_byte[7];
                bit_r    <= 4'h1;
                state_r  <= ST_TX;
              end else begin
                sda_oe_r <= 1'b0;
                state_r  <= ST_RX;
                phase_r  <= phase_r + 2'h1;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_r == `EE_BYTE_BITS) begin
                sda_oe_r <= 1'b0;
                state_r  <= ST_MACK;
              end else begin
                sda_oe_r <= ~tx_r[6];
                tx_r     <= {tx_r[6:0], 1'b1};
                bit_r    <= bit_r + 1'b1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              host_ack_r <= ~sda_s2_r;
              ptr_r      <= ptr_inc;
            end else if (scl_fall) begin
              if (load_tx) begin
                tx_r     <= tx_byte;
                sda_oe_r <= ~tx_byte[7];
                bit_r    <= 4'h1;
                state_r  <= ST_TX;
              end else begin
                sda_oe_r <= 1'b0;
                state_r  <= ST_WAIT;
              end
            end
          end
          default: begin
            state_r  <= ST_IDLE;
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // prefetch address tracks the pointer so the fifo head is ptr_r
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      fetch_r <= `EE_PTR_RESET;
    end else if (clk_en_i) begin
      if (flush_r)
        fetch_r <= ptr_r;
      else if (rd_valid_i && rd_ready_o)
        fetch_r <= fetch_inc;
    end
  end

  byte_fifo #(
    .WIDTH (`EE_FIFO_WIDTH),
    .DEPTH (`EE_FIFO_DEPTH),
    .AW    (`EE_FIFO_AW)
  ) i_byte_fifo (
    .clk_i       (ref_clk_i),
    .resetn_i    (resetn_i),
    .clk_en_i    (clk_en_i),
    .flush_i     (flush_r),
    .in_valid_i  (rd_valid_i),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (rd_data_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (load_tx),
    .out_data_o  (fifo_data)
  );
endmodule

`default_nettype wire

// File: hdl/placeholder_none.v
// intentionally empty design unit list terminator
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: bench/eeprom_read_engine_asserts.sv
// port checker of the eeprom read engine
`timescale 1ns/1ps
`default_nettype none
module eeprom_read_engine_asserts (
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        resetn_i,
  // serial bus
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_o,
  // array port and pointer
  input wire logic [12:0] rd_addr_o,
  input wire logic        rd_valid_i,
  input wire logic        rd_ready_o,
  input wire logic [12:0] ptr_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  a_drive_zero: assert property (sda_o == 1'b0)
    else $error("data pin output not zero");
  a_reset_idle: assert property ($rose(resetn_i) |-> !sda_oe_o &&
    ptr_o == 13'h0000 && rd_addr_o == 13'h0000 && rd_ready_o)
    else $error("not idle after reset");
  a_fetch_step: assert property (rd_valid_i && rd_ready_o |=>
    rd_addr_o == $past(rd_addr_o) + 13'h0001)
    else $error("fetch address did not step by one");
  a_full_hold: assert property (!rd_ready_o && !$past(rd_ready_o) |->
    $stable(rd_addr_o))
    else $error("fetch address moved while full");
  a_oe_rise_low: assert property ($rose(sda_oe_o) |->
    !$past(scl_i, 2) && !$past(scl_i, 3))
    else $error("data line pulled while bus clock high");
  a_stop_release: assert property ($rose(sda_i) && scl_i &&
    $past(scl_i) |-> ##[1:6] (!sda_oe_o && rd_addr_o == ptr_o))
    else $error("no release or refetch after stop");
  a_start_release: assert property ($fell(sda_i) && scl_i &&
    $past(scl_i) |-> ##[1:6] (!sda_oe_o && rd_addr_o == ptr_o))
    else $error("no release or refetch after start");
  a_load_flush: assert property ($changed(ptr_o) &&
    ptr_o != $past(ptr_o) + 13'h0001 |-> ##[0:3] !rd_ready_o)
    else $error("no refetch after pointer load");
endmodule

bind eeprom_read_engine eeprom_read_engine_asserts
  i_eeprom_read_engine_asserts (
  .ref_clk_i, .resetn_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
  .rd_addr_o, .rd_valid_i, .rd_ready_o, .ptr_o);
`default_nettype wire

// File: bench/bus_host_model.sv
// behavioural two-wire bus host that owns the serial clock
`timescale 1ns/1ps
`default_nettype none
module bus_host_model (
  // bus pins, data is open drain
  output logic      scl_o,
  output logic      sda_low_o,
  input  wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // data moves after the device has seen scl fall; every pin change
  // lands on a falling ref clock edge, clear of the sampling edge
  task automatic bit_cyc(input logic low, output logic s);
    #120 sda_low_o = low;
    #80 scl_o = 1'b1;
    #80 s = sda_i;
    #40 scl_o = 1'b0;
  endtask
  task automatic start_cond();
    #200 sda_low_o = 1'b0;
    #40 scl_o = 1'b1;
    #160 sda_low_o = 1'b1;
    #160 scl_o = 1'b0;
  endtask
  task automatic stop_cond();
    #200 sda_low_o = 1'b1;
    #40 scl_o = 1'b1;
    #160 sda_low_o = 1'b0;
    #160;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(~b[i], s);
    bit_cyc(1'b0, s);
    ack = ~s;
  endtask
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(1'b0, d[i]);
    bit_cyc(ack, s);
  endtask
endmodule
`default_nettype wire

// File: bench/test_eeprom_read_engine.sv
// self-checking bench of the eeprom read engine
`timescale 1ns/1ps
`default_nettype none
module test_eeprom_read_engine;
  localparam logic [2:0] CS = 3'h5;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        busy = 1'b0;
  logic        scl;
  logic        host_low;
  wire         sda_o;
  wire         sda_oe;
  wire         rd_ready;
  wire  [12:0] rd_addr;
  wire  [12:0] ptr;
  int          error_cnt = 0;
  int          checked = 0;
  int          cyc = 0;
  // released line floats high through the pull-up
  wire         sda = ~(host_low | sda_oe);
  function automatic logic [7:0] mem(input logic [12:0] a);
    return a[7:0] ^ {3'h0, a[12:8]};
  endfunction
  wire  [7:0]  rd_data = mem(rd_addr);
  always #20 clk = ~clk;

  eeprom_read_engine i_eeprom_read_engine (
    .ref_clk_i(clk), .resetn_i(resetn), .clk_en_i(1'b1),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .chip_select_pins_i(CS), .prog_busy_i(busy),
    .rd_addr_o(rd_addr), .rd_data_i(rd_data), .rd_valid_i(1'b1),
    .rd_ready_o(rd_ready), .ptr_o(ptr));
  bus_host_model i_bus_host_model (
    .scl_o(scl), .sda_low_o(host_low), .sda_i(sda));

  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // write header with address only, left open for a restart
  task automatic load_addr(input logic [15:0] a);
    logic k;
    i_bus_host_model.start_cond();
    i_bus_host_model.send_byte({4'hA, CS, 1'b0}, k);
    chk(13'(k), 13'h0001);
    i_bus_host_model.send_byte(a[15:8], k);
    chk(13'(k), 13'h0001);
    i_bus_host_model.send_byte(a[7:0], k);
    chk(13'(k), 13'h0001);
    @(negedge clk);
    chk(ptr, a[12:0]);
  endtask
  // read n bytes from the pointer, acking all but the last
  task automatic rd_seq(input logic [12:0] a, input int n);
    logic k;
    logic [7:0] d;
    i_bus_host_model.start_cond();
    i_bus_host_model.send_byte({4'hA, CS, 1'b1}, k);
    chk(13'(k), 13'h0001);
    for (int i = 0; i < n; i++) begin
      i_bus_host_model.recv_byte(i != n - 1, d);
      chk(13'(d), 13'(mem(a + 13'(i))));
    end
    repeat (4) @(negedge clk);
    chk(13'(sda_oe), 13'h0000);
    i_bus_host_model.stop_cond();
    @(negedge clk);
    chk(ptr, a + 13'(n));
    chk(13'(sda_oe), 13'h0000);
  endtask
  task automatic refuse(input logic [7:0] c);
    logic k;
    i_bus_host_model.start_cond();
    i_bus_host_model.send_byte(c, k);
    chk(13'(k), 13'h0000);
    i_bus_host_model.stop_cond();
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  initial begin
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    chk(ptr, 13'h0000);
    load_addr(16'hE123);
    rd_seq(13'h0123, 1);
    rd_seq(13'h0124, 1);
    load_addr(16'h1FFE);
    rd_seq(13'h1FFE, 3);
    refuse({4'hA, ~CS, 1'b1});
    refuse({4'h5, CS, 1'b1});
    busy = 1'b1;
    refuse({4'hA, CS, 1'b1});
    busy = 1'b0;
    chk(ptr, 13'h0001);
    rd_seq(13'h0001, 2);
    complete_run();
  end
endmodule
`default_nettype wire
